/* verilog/oclm_map.svh */
// register offsets, reset values and timing counts for the fault limit block
`ifndef OCLM_MAP_SVH
`define OCLM_MAP_SVH

`define OCLM_CMD_OC_WARN      8'h4a
`define OCLM_CMD_OT_FAULT     8'h4f
`define OCLM_OT_FAULT_RST     16'h007d
`define OCLM_OC_ACTION_RST    8'hfa
`define OCLM_EXP_MSB          15
`define OCLM_EXP_LSB          11
`define OCLM_MAN_MSB          10
`define OCLM_MAN_LSB          0
`define OCLM_RESTART_MS       22
`define OCLM_CLK_MHZ          200
`define OCLM_RESTART_CYC      (`OCLM_RESTART_MS * 1000 * `OCLM_CLK_MHZ)
`define OCLM_OC_FAULT_PCT     125
`define OCLM_PCT_DIV          100

`endif

/* verilog/oclm_pkg.sv */
// shared types for the fault limit block
package oclm_pkg;
    // linear word: exponent and mantissa
    typedef struct packed {
        logic [4:0]  exponent;
        logic [10:0] mantissa;
    } oclm_linear_s;

    // register write request from the command decoder
    typedef struct packed {
        logic        wr;
        logic [7:0]  cmd;
        logic [15:0] data;
    } oclm_cmd_s;

    // status bits seen by the host
    typedef struct packed {
        logic byte_other;
        logic byte_iout_oc;
        logic byte_temp;
        logic word_iout;
        logic iout_oc_fault;
        logic iout_oc_warn;
        logic temp_ot_fault;
    } oclm_status_s;

    typedef enum logic [1:0] {
        OCLM_RUN,
        OCLM_WAIT
    } oclm_state_e;
endpackage

/* verilog/oclm_limits.sv */
// overcurrent and over-temperature limit compare, status and restart timing
`timescale 1ns/1ps
`include "oclm_map.svh"

module oclm_limits
    import oclm_pkg::*;
(
    // clock, reset, enable
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // limit command access from the bus controller
    input  wire oclm_cmd_s    cmd_in,
    input  wire logic [7:0]   rd_cmd,
    output logic      [15:0]  rd_data,
    input  wire logic         status_clr,
    // telemetry in linear format
    input  wire logic [15:0]  iout_meas,
    input  wire logic [15:0]  temp_meas,
    input  wire logic [15:0]  max_current_setting,
    // status and pins
    output oclm_status_s      status,
    output logic              host_alert_line,
    output logic              regulator_fault_pin,
    output logic              output_enable
);

    // the block watches three conditions on every enabled cycle:
    //   - output current at or above the warning limit
    //   - output current at or above 125 percent of the max setting
    //   - temperature at or above the over-temperature limit
    // each raises sticky status and the alert; only the current fault
    // touches the output, directly and through the restart machine below
    // limits written by the host take effect on the cycle after the
    // write strobe; a limit written below the present reading trips
    // the matching condition on that very cycle

    // restart wait: 22 ms at the 200 MHz system clock is 4.4M cycles, so
    // a 32-bit down counter is plenty; the count is fixed, which means a
    // bench cannot shorten it and has to watch the first part of the wait
    localparam int unsigned RESTART_CYC = `OCLM_RESTART_CYC;
    // last count value of the wait, loaded on entry
    localparam logic [31:0] RESTART_LAST = 32'(RESTART_CYC - 1);

    // scale a linear word to a fixed-point value with 16 fraction bits
    function automatic logic signed [63:0] lin_value(input logic [15:0] w);
        logic signed [4:0]  e;
        logic signed [63:0] m;
        e = w[`OCLM_EXP_MSB:`OCLM_EXP_LSB];
        m = 64'(signed'(w[`OCLM_MAN_MSB:`OCLM_MAN_LSB]));
        m = m <<< 16;
        if (e < 0) begin
            lin_value = m >>> (-e);
        end else begin
            lin_value = m <<< e;
        end
    endfunction

    // every limit and every telemetry word goes through lin_value, so a
    // limit with a different exponent than the reading still compares
    // right; the 16 fraction bits keep negative exponents exact down to
    // 2^-16, the most negative exponent the 5-bit field can hold,
    // so no word of any exponent is ever truncated

    // sticky flag step: a set in the same cycle as a clear wins, so an
    // event still present when the host clears shows up again at once
    function automatic logic sticky_next(input logic set,
                                         input logic held,
                                         input logic clr);
        sticky_next = set | (held & ~clr);
    endfunction

    logic [15:0]  oc_warn_q;
    logic [15:0]  ot_fault_q;
    oclm_state_e  state_q;
    logic [31:0]  wait_cnt_q;
    oclm_status_s status_q;
    logic         alert_q;
    logic         vrf_q;
    logic [15:0]  rd_data_q;
    oclm_status_s status_d;
    logic         alert_d;
    logic         vrf_d;

    // threshold compares in a common fixed-point scale
    // the fault level is the max current setting scaled by 125/100;
    // the product is taken before the divide, so the result is exact for setting exponents of -14 and above
    // all compares are "at or above", so a reading equal to the limit
    // already counts as reaching it
    wire logic signed [63:0] iout_val  = lin_value(iout_meas);
    wire logic signed [63:0] max_current_setting_val  = lin_value(max_current_setting);
    wire logic signed [63:0] fault_val = (max_current_setting_val * 64'sd`OCLM_OC_FAULT_PCT)
                                         / 64'sd`OCLM_PCT_DIV;
    wire logic oc_warn  = iout_val >= lin_value(oc_warn_q);
    wire logic oc_fault = iout_val >= fault_val;
    wire logic ot_fault = lin_value(temp_meas) >= lin_value(ot_fault_q);
    // write decode; strobes to any other command code are dropped
    wire logic wr_warn  = cmd_in.wr && cmd_in.cmd == `OCLM_CMD_OC_WARN;
    wire logic wr_ot    = cmd_in.wr && cmd_in.cmd == `OCLM_CMD_OT_FAULT;
    wire logic fault_go = state_q == OCLM_RUN && oc_fault;

    // read mux; fault action is a fixed read-only byte
    // it is not offered on this port, so unknown codes read as zero
    // rather than as stale data from an earlier request
    wire logic [15:0] rd_mux =
        (rd_cmd == `OCLM_CMD_OC_WARN)  ? oc_warn_q  :
        (rd_cmd == `OCLM_CMD_OT_FAULT) ? ot_fault_q : 16'h0000;

    // limit registers; warning limit powers up at zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_warn_q  <= 16'h0000;
            ot_fault_q <= `OCLM_OT_FAULT_RST;
        end else if (clk_en) begin
            if (wr_warn) begin
                oc_warn_q <= cmd_in.data;
            end
            if (wr_ot) begin
                ot_fault_q <= cmd_in.data;
            end
        end
    end

    // read data register; not reset, the host reads only after a request
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            rd_data_q <= rd_mux;
        end
    end

    // shutdown and timed restart; only a fault enters the wait
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= OCLM_RUN;
            wait_cnt_q <= 32'h0000_0000;
        end else if (clk_en) begin
            case (state_q)
                // output on; a fault drops it and starts the wait
                OCLM_RUN: begin
                    if (oc_fault) begin
                        state_q    <= OCLM_WAIT;
                        wait_cnt_q <= RESTART_LAST;
                    end
                end
                // output off; a fault that persists past the wait trips
                // again on the first cycle back in RUN
                OCLM_WAIT: begin
                    if (wait_cnt_q == 32'h0000_0000) begin
                        state_q <= OCLM_RUN;
                    end else begin
                        wait_cnt_q <= wait_cnt_q - 32'h0000_0001;
                    end
                end
                default: state_q <= OCLM_RUN;
            endcase
        end
    end

    // per-bit next values of the sticky status; the warning only feeds
    // status and alert, never the restart machine
    wire logic other_d    = sticky_next(oc_warn, status_q.byte_other, status_clr);
    wire logic iout_w_d   = sticky_next(oc_warn | fault_go, status_q.word_iout,
                                        status_clr);
    wire logic warn_bit_d = sticky_next(oc_warn, status_q.iout_oc_warn, status_clr);
    wire logic oc_byte_d  = sticky_next(fault_go, status_q.byte_iout_oc, status_clr);
    wire logic oc_bit_d   = sticky_next(fault_go, status_q.iout_oc_fault, status_clr);
    wire logic temp_b_d   = sticky_next(ot_fault, status_q.byte_temp, status_clr);
    wire logic ot_bit_d   = sticky_next(ot_fault, status_q.temp_ot_fault, status_clr);

    // status word packed msb first, in the order of the struct
    assign status_d = {other_d, oc_byte_d, temp_b_d, iout_w_d,
                       oc_bit_d, warn_bit_d, ot_bit_d};

    // alert follows any of the three events; the fault pin only the
    // temperature fault, so a host can tell the two apart on the board
    assign alert_d = sticky_next(oc_warn | fault_go | ot_fault, alert_q,
                                 status_clr);
    assign vrf_d   = sticky_next(ot_fault, vrf_q, status_clr);

    // sticky status registers; frozen while the enable is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_q <= '0;
            alert_q  <= 1'b0;
            vrf_q    <= 1'b0;
        end else if (clk_en) begin
            status_q <= status_d;
            alert_q  <= alert_d;
            vrf_q    <= vrf_d;
        end
    end

    // output stage
    // warning has no path into output_enable, only status and alert;
    // a fault drops the enable in the same cycle it is seen, before the
    // state register has caught up, so the output is never late by one
    assign output_enable       = state_q == OCLM_RUN && !oc_fault;
    assign status              = status_q;
    assign host_alert_line     = alert_q;
    assign regulator_fault_pin = vrf_q;
    assign rd_data             = rd_data_q;

endmodule

/* verification/oclm_limits_chk.sv */
// port assertions for the fault limit block
`timescale 1ns/1ps
module oclm_limits_chk
    import oclm_pkg::*;
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst,
    // status and pins
    input wire oclm_status_s status,
    input wire logic         host_alert_line,
    input wire logic         regulator_fault_pin,
    input wire logic         output_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence warn_up; $rose(status.iout_oc_warn); endsequence
    warn_bits_a: assert property (warn_up |-> status.byte_other && status.word_iout)
        else $error("warn bits");
    warn_alert_a: assert property (warn_up |-> host_alert_line)
        else $error("warn alert");
    warn_run_a: assert property (warn_up ##0 !status.iout_oc_fault |-> output_enable)
        else $error("warn stop");
    fault_off_a: assert property ($rose(status.iout_oc_fault) |-> !output_enable [*8])
        else $error("no shutdown");
    fault_bits_a: assert property ($rose(status.iout_oc_fault) |-> status.byte_iout_oc)
        else $error("fault bits");
    temp_bits_a: assert property ($rose(status.temp_ot_fault) |-> status.byte_temp)
        else $error("temp bits");
    temp_pins_a: assert property ($rose(status.temp_ot_fault) |-> regulator_fault_pin)
        else $error("temp pin");
    pin_cause_a: assert property (regulator_fault_pin |-> status.temp_ot_fault)
        else $error("pin cause");
endmodule
bind oclm_limits oclm_limits_chk u_chk (.sys_clk, .rst, .status, .host_alert_line,
    .regulator_fault_pin, .output_enable);

/* verification/oclm_host_model.sv */
// host model writing and reading limit commands
`timescale 1ns/1ps
module oclm_host_model
    import oclm_pkg::*;
(
    // clock
    input wire logic        sys_clk,
    // command access
    output oclm_cmd_s       cmd_in,
    output logic [7:0]      rd_cmd,
    input wire logic [15:0] rd_data
);
    initial cmd_in = '0;
    initial rd_cmd = 8'h00;
    // one-cycle strobe, word sent as exponent then mantissa
    task automatic write(input logic [7:0] c, input oclm_linear_s w);
        @(posedge sys_clk) cmd_in <= {1'b1, c, w};
        @(posedge sys_clk) cmd_in.wr <= 1'b0;
    endtask
    // registered answer, sampled one edge late to be safe
    task automatic read(input logic [7:0] c, output logic [15:0] d);
        @(posedge sys_clk) rd_cmd <= c;
        repeat (2) @(posedge sys_clk);
        #1 d = rd_data;
    endtask
endmodule

/* verification/test_overcurrent_overtemp_limits.sv */
// self-checking bench for the fault limit block
`timescale 1ns/1ps
module test_overcurrent_overtemp_limits import oclm_pkg::*;;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         clk_en = 1'b1;
    logic         status_clr = 1'b0;
    logic [15:0]  iout_meas = 16'h0000;
    logic [15:0]  temp_meas = 16'h0019;
    logic [15:0]  max_current_setting = 16'h0040;
    oclm_cmd_s    cmd_in;
    logic [7:0]   rd_cmd;
    logic [15:0]  rd_data, v;
    oclm_status_s status;
    logic         host_alert_line, regulator_fault_pin, output_enable;
    int           n_errors = 0, compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    oclm_limits i_dut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .clk_en              (clk_en),
        .cmd_in              (cmd_in),
        .rd_cmd              (rd_cmd),
        .rd_data             (rd_data),
        .status_clr          (status_clr),
        .iout_meas           (iout_meas),
        .temp_meas           (temp_meas),
        .max_current_setting (max_current_setting),
        .status              (status),
        .host_alert_line     (host_alert_line),
        .regulator_fault_pin (regulator_fault_pin),
        .output_enable       (output_enable)
    );
    oclm_host_model i_host (.sys_clk, .cmd_in, .rd_cmd, .rd_data);
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // alert, pin, enable and sticky bits as one word
    function automatic logic [15:0] pins;
        return {6'h00, host_alert_line, regulator_fault_pin, output_enable, status};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // clear is issued quietly, so the idle word must come back to enable only
    task automatic clear;
        @(posedge sys_clk) status_clr <= 1'b1;
        @(posedge sys_clk) status_clr <= 1'b0;
        step(1);
        chk(pins(), 16'h0080);
    endtask
    task automatic sc_defaults;
        i_host.write(8'h46, 16'h1234);
        i_host.read(8'h4a, v);
        chk(v, 16'h0000);
        i_host.read(8'h4f, v);
        chk(v, 16'h007d);
        i_host.read(8'h46, v);
        chk(v, 16'h0000);
    endtask
    // limit 8*2^1 = 16 A with a nonzero exponent; 15 A stays quiet
    task automatic sc_warn;
        i_host.write(8'h4a, 16'h0808);
        i_host.read(8'h4a, v);
        chk(v, 16'h0808);
        @(posedge sys_clk) iout_meas <= 16'h000f;
        clear;
        @(posedge sys_clk) iout_meas <= 16'h0010;
        step(2);
        chk(pins(), 16'h02ca);
        @(posedge sys_clk) iout_meas <= 16'h0000;
        clear;
    endtask
    task automatic sc_temp;
        @(posedge sys_clk) temp_meas <= 16'h007c;
        step(2);
        chk(pins(), 16'h0080);
        @(posedge sys_clk) temp_meas <= 16'h007e;
        step(2);
        chk(pins(), 16'h0391);
        @(posedge sys_clk) temp_meas <= 16'h0019;
        clear;
    endtask
    // frozen block ignores a fault; a clear that meets a live event loses
    task automatic sc_freeze;
        @(posedge sys_clk) clk_en <= 1'b0;
        temp_meas <= 16'h007e;
        step(3);
        chk(pins(), 16'h0080);
        @(posedge sys_clk) clk_en <= 1'b1;
        step(2);
        chk(pins(), 16'h0391);
        @(posedge sys_clk) status_clr <= 1'b1;
        @(posedge sys_clk) status_clr <= 1'b0;
        step(1);
        chk(pins(), 16'h0391);
        @(posedge sys_clk) temp_meas <= 16'h0019;
        clear;
    endtask
    // 80 A is exactly 125 percent of the 64 A setting
    task automatic sc_fault;
        @(posedge sys_clk) iout_meas <= 16'h0050;
        step(2);
        chk(pins(), 16'h026e);
        @(posedge sys_clk) iout_meas <= 16'h0000;
        step(1000);
        chk(pins(), 16'h026e);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        sc_defaults;
        sc_warn;
        sc_temp;
        sc_freeze;
        sc_fault;
        report_and_stop;
    end
endmodule
